/* File: hdl/reset_seq_pkg.sv */
/*
 * shared constants and carriers for the power-on reset timer.
 * assumes a single 250 MHz core clock; the slow internal rc oscillator
 * and the instruction clock are enable pulses derived from it.
 */
`default_nettype none

package reset_seq_pkg;

    // clock and time base
    localparam int CLK_PERIOD_NS  = 4;
    localparam int RC_PERIOD_NS   = 4000;   // nominal internal rc oscillator period
    localparam int DELAY_TIME_MS  = 18;     // nominal reset delay
    localparam int RC_DIV_CYCLES  = (RC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DELAY_TICKS    = (DELAY_TIME_MS * 1000000) / RC_PERIOD_NS;
    localparam int INSTR_DIV      = 4;      // instruction clock is core clock over four

    // counter widths and reset values
    localparam int          RC_DIV_W     = 10;
    localparam int          DELAY_CNT_W  = 24;
    localparam int          PC_MAX_W     = 11;
    localparam logic [9:0]  RC_DIV_RST   = 10'h000;
    localparam logic [23:0] DELAY_CNT_RST = 24'h000000;
    localparam logic [1:0]  INSTR_RST    = 2'h0;
    localparam logic [1:0]  FLAGS_POR    = 2'h3;    // timeout, powerdown after power-on
    localparam logic        SYNC_RST     = 1'h0;

    // reset cause flags, both active low
    typedef struct packed {
        logic timeout_n;
        logic powerdown_n;
    } cause_flags_t;

    // requests from the core side
    typedef struct packed {
        logic                advance;
        logic                load;
        logic [PC_MAX_W-1:0] addr;
    } pc_req_t;

endpackage : reset_seq_pkg

`default_nettype wire

/* File: hdl/pin_sync3.sv */
/*
 * three-stage synchroniser for an asynchronous pin.
 * the output changes only once stages two and three agree.
 * assumes the pin is quasi-static compared with the core clock.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic pin_in,
    output logic      level_out
);

    logic stage1_reg;
    logic stage2_reg;
    logic stage3_reg;

    // shift chain; stage1 feeds stage2 only
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage1_reg <= reset_seq_pkg::SYNC_RST;
            stage2_reg <= reset_seq_pkg::SYNC_RST;
            stage3_reg <= reset_seq_pkg::SYNC_RST;
        end else begin
            stage1_reg <= pin_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // accept a new level once two stages agree
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            level_out <= reset_seq_pkg::SYNC_RST;
        end else if (stage2_reg == stage3_reg) begin
            level_out <= stage3_reg;
        end
    end

endmodule : pin_sync3

`default_nettype wire

/* File: hdl/power_on_reset_timer.sv */
/*
 * reset latch, reset delay timer, reset cause flags and program counter
 * reset vector handling for a small 8-bit controller core.
 * assumes rst_n_in models the power-up detector, master_clear_n comes from
 * a pin, and watchdog and sleep signals come from logic on core_clk_in.
 */
`timescale 1ns/1ps
`default_nettype none

module power_on_reset_timer #(
    parameter int PC_WIDTH  = 11,
    parameter int DELAY_TICKS = reset_seq_pkg::DELAY_TICKS
) (
    input  wire logic                                 core_clk_in,
    input  wire logic                                 rst_n_in,
    input  wire logic                                 master_clear_n_in,
    input  wire logic                                 watchdog_timeout_in,
    input  wire logic                                 sleep_in,
    input  wire reset_seq_pkg::pc_req_t               pc_req_in,
    output logic                                      core_reset_out,
    output logic                                      instr_en_out,
    output var reset_seq_pkg::cause_flags_t           cause_flags_out,
    output logic [reset_seq_pkg::PC_MAX_W-1:0]        pc_out
);

    typedef enum logic [1:0] {
        ST_WAIT_CLEAR,
        ST_TIMING,
        ST_RELEASE,
        ST_RUN
    } seq_state_t;

    seq_state_t                            state_reg;
    seq_state_t                            state_next;
    logic                                  clear_high;
    logic [reset_seq_pkg::RC_DIV_W-1:0]    rc_div_reg;
    logic                                  rc_tick_reg;
    logic [1:0]                            instr_div_reg;
    logic [reset_seq_pkg::DELAY_CNT_W-1:0] delay_count_reg;
    logic                                  delay_done;
    logic                                  wake_clear;
    logic                                  wake_watchdog;

    // mask of implemented program address bits
    function automatic logic [reset_seq_pkg::PC_MAX_W-1:0] pc_mask(input int width);
        pc_mask = ~(({reset_seq_pkg::PC_MAX_W{1'b1}}) << width);
    endfunction : pc_mask

    localparam logic [reset_seq_pkg::PC_MAX_W-1:0] PC_VECTOR = pc_mask(PC_WIDTH);
    localparam logic [reset_seq_pkg::DELAY_CNT_W-1:0] DELAY_LAST =
        reset_seq_pkg::DELAY_CNT_W'(DELAY_TICKS - 1);

    // master clear pin into the core clock domain
    pin_sync3 u_clear_sync (
        .clk_in    (core_clk_in),
        .rst_n_in  (rst_n_in),
        .pin_in    (master_clear_n_in),
        .level_out (clear_high)
    );

    // internal rc time base, free running regardless of oscillator mode
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rc_div_reg  <= reset_seq_pkg::RC_DIV_RST;
            rc_tick_reg <= 1'b0;
        end else if (rc_div_reg ==
                     reset_seq_pkg::RC_DIV_W'(reset_seq_pkg::RC_DIV_CYCLES - 1)) begin
            rc_div_reg  <= reset_seq_pkg::RC_DIV_RST;
            rc_tick_reg <= 1'b1;
        end else begin
            rc_div_reg  <= rc_div_reg + 1'b1;
            rc_tick_reg <= 1'b0;
        end
    end

    // instruction clock enable, one pulse every four core cycles
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            instr_div_reg <= reset_seq_pkg::INSTR_RST;
            instr_en_out  <= 1'b0;
        end else begin
            instr_div_reg <= instr_div_reg + 1'b1;
            instr_en_out  <= (instr_div_reg == 2'(reset_seq_pkg::INSTR_DIV - 1));
        end
    end

    assign delay_done    = rc_tick_reg && (delay_count_reg == DELAY_LAST);
    assign wake_clear    = (state_reg == ST_RUN) && !clear_high;
    assign wake_watchdog = (state_reg == ST_RUN) && watchdog_timeout_in;

    // reset latch sequencing
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_WAIT_CLEAR: begin
                if (clear_high) begin
                    state_next = ST_TIMING;
                end
            end
            ST_TIMING: begin
                if (!clear_high) begin
                    state_next = ST_WAIT_CLEAR;
                end else if (!watchdog_timeout_in && delay_done) begin
                    state_next = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                if (!clear_high) begin
                    state_next = ST_WAIT_CLEAR;
                end else if (watchdog_timeout_in) begin
                    state_next = ST_TIMING;
                end else if (instr_en_out) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (wake_clear) begin
                    state_next = ST_WAIT_CLEAR;
                end else if (wake_watchdog) begin
                    state_next = ST_TIMING;
                end
            end
        endcase
    end

    // state and registered reset output; power-up is the only async source
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg      <= ST_WAIT_CLEAR;
            core_reset_out <= 1'b1;
        end else begin
            state_reg      <= state_next;
            core_reset_out <= (state_next != ST_RUN);
        end
    end

    // reset delay timer, cleared whenever it is not timing
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            delay_count_reg <= reset_seq_pkg::DELAY_CNT_RST;
        end else if (state_next != ST_TIMING || watchdog_timeout_in
                     || state_reg != ST_TIMING) begin
            delay_count_reg <= reset_seq_pkg::DELAY_CNT_RST;
        end else if (rc_tick_reg) begin
            delay_count_reg <= delay_count_reg + 1'b1;
        end
    end

    // reset cause flags
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cause_flags_out <= reset_seq_pkg::FLAGS_POR;
        end else if (wake_clear && sleep_in) begin
            cause_flags_out <= '{timeout_n: 1'b1, powerdown_n: 1'b0};
        end else if (wake_clear) begin
            cause_flags_out <= cause_flags_out;
        end else if (wake_watchdog) begin
            cause_flags_out <= '{timeout_n: 1'b0, powerdown_n: !sleep_in};
        end
    end

    // program counter with reset vector and wraparound
    // the leaving edge still loads the vector, so the first fetch is at the vector
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pc_out <= PC_VECTOR;
        end else if (state_next != ST_RUN || state_reg != ST_RUN) begin
            pc_out <= PC_VECTOR;
        end else if (pc_req_in.load) begin
            pc_out <= pc_req_in.addr & PC_VECTOR;
        end else if (pc_req_in.advance) begin
            pc_out <= (pc_out + 1'b1) & pc_mask(PC_WIDTH);
        end
    end

    // checks
    sequence s_expire;
        state_reg == ST_TIMING && clear_high && !watchdog_timeout_in && delay_done;
    endsequence

    sequence s_released;
        state_reg == ST_RELEASE ##[0:4] !core_reset_out;
    endsequence

    property p_latch_holds;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        state_reg != ST_RUN |-> core_reset_out;
    endproperty
    a_latch_holds: assert property (p_latch_holds) else $error("core left reset early");

    property p_no_count_low;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        !clear_high |=> delay_count_reg == reset_seq_pkg::DELAY_CNT_RST;
    endproperty
    a_no_count_low: assert property (p_no_count_low) else $error("timer ran with clear low");

    property p_expire_release;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        s_expire |=> s_released;
    endproperty
    a_expire_release: assert property (p_expire_release) else $error("latch not released");

    property p_rc_spacing;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        rc_tick_reg |=> !rc_tick_reg [*8];
    endproperty
    a_rc_spacing: assert property (p_rc_spacing) else $error("rc tick too frequent");

    property p_wdt_restart;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        wake_watchdog && clear_high |=> state_reg == ST_TIMING
            && delay_count_reg == reset_seq_pkg::DELAY_CNT_RST && core_reset_out;
    endproperty
    a_wdt_restart: assert property (p_wdt_restart) else $error("watchdog did not restart");

    property p_flags_wdt;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        wake_watchdog && clear_high |=> !cause_flags_out.timeout_n
            && cause_flags_out.powerdown_n == !$past(sleep_in);
    endproperty
    a_flags_wdt: assert property (p_flags_wdt) else $error("watchdog flags wrong");

    property p_flags_clear;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        wake_clear |=> ($past(sleep_in) ? cause_flags_out == 2'h2 : $stable(cause_flags_out));
    endproperty
    a_flags_clear: assert property (p_flags_clear) else $error("master clear flags wrong");

    property p_wake_reset;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        wake_clear && sleep_in |=> core_reset_out && pc_out == PC_VECTOR;
    endproperty
    a_wake_reset: assert property (p_wake_reset) else $error("wake did not reset");

    property p_vector;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        core_reset_out |-> pc_out == PC_VECTOR;
    endproperty
    a_vector: assert property (p_vector) else $error("pc not at reset vector");

    property p_wrap;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        pc_out == PC_VECTOR && state_reg == ST_RUN && state_next == ST_RUN
            && pc_req_in.advance && !pc_req_in.load |=> pc_out == 11'h000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("pc did not wrap to zero");

    property p_release_sync;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        $fell(core_reset_out) |-> $past(instr_en_out);
    endproperty
    a_release_sync: assert property (p_release_sync) else $error("release not aligned");

endmodule : power_on_reset_timer

`default_nettype wire

/* File: tb/master_clear_source.sv */
/*
 * model of the outside master clear source, an rc network or supervisor.
 * assumes supply_ok_in says whether the supply is inside its limits.
 */
`timescale 1ns/1ps
`default_nettype none

module master_clear_source #(
    parameter int SETTLE = 2
) (
    input  wire logic clk_in,
    input  wire logic supply_ok_in,
    output logic      master_clear_n_out
);
    logic [7:0] settle_reg = 8'h00;

    // count how long the supply has been good, restart on any dip
    always_ff @(posedge clk_in) begin
        if (!supply_ok_in) begin
            settle_reg <= 8'h00;
        end else if (settle_reg < 8'(SETTLE)) begin
            settle_reg <= settle_reg + 8'h01;
        end
    end

    // pin low on a dip and until the supply has settled
    assign master_clear_n_out = supply_ok_in && (settle_reg >= 8'(SETTLE));
endmodule : master_clear_source

`default_nettype wire

/* File: tb/power_on_reset_timer_tb.sv */
/*
 * self-checking bench for the power-on reset timer, an 11-bit and a 9-bit copy.
 * assumes a short delay parameter and the partner model for the clear pin.
 */
`timescale 1ns/1ps
`default_nettype none

module power_on_reset_timer_tb;
    localparam int DT     = 3;
    localparam int SETTLE = 2;
    localparam int LO     = (DT - 1) * reset_seq_pkg::RC_DIV_CYCLES;
    localparam int HI     = DT * reset_seq_pkg::RC_DIV_CYCLES + 24 + SETTLE;

    logic                              core_clk    = 1'b0;
    logic                              rst_n       = 1'b0;
    logic                              supply_ok   = 1'b0;
    logic                              watchdog    = 1'b0;
    logic                              sleep       = 1'b0;
    reset_seq_pkg::pc_req_t            pc_req      = '0;
    logic                              master_clear_n;
    logic                              core_reset;
    logic                              core_reset9;
    logic                              instr_en;
    reset_seq_pkg::cause_flags_t       flags;
    logic [reset_seq_pkg::PC_MAX_W-1:0] pc;
    logic [reset_seq_pkg::PC_MAX_W-1:0] pc9;
    int                                fail_count  = 0;
    int                                comparisons = 0;

    always #(reset_seq_pkg::CLK_PERIOD_NS / 2.0) core_clk = ~core_clk;

    master_clear_source #(.SETTLE(SETTLE)) mc_src (
        .clk_in(core_clk), .supply_ok_in(supply_ok), .master_clear_n_out(master_clear_n));

    power_on_reset_timer #(.PC_WIDTH(11), .DELAY_TICKS(DT)) uut (
        .core_clk_in(core_clk), .rst_n_in(rst_n), .master_clear_n_in(master_clear_n),
        .watchdog_timeout_in(watchdog), .sleep_in(sleep), .pc_req_in(pc_req),
        .core_reset_out(core_reset), .instr_en_out(instr_en),
        .cause_flags_out(flags), .pc_out(pc));

    power_on_reset_timer #(.PC_WIDTH(9), .DELAY_TICKS(DT)) uut_narrow (
        .core_clk_in(core_clk), .rst_n_in(rst_n), .master_clear_n_in(master_clear_n),
        .watchdog_timeout_in(watchdog), .sleep_in(sleep), .pc_req_in(pc_req),
        .core_reset_out(core_reset9), .instr_en_out(),
        .cause_flags_out(), .pc_out(pc9));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) begin
            @(posedge core_clk);
            #1;
        end
    endtask : step

    // wait for the core to leave reset, counting cycles
    task automatic wait_release(output int n);
        logic prev_en;
        n = 0;
        prev_en = instr_en;
        while (core_reset === 1'b1 && n < 8000) begin
            prev_en = instr_en;
            step(1);
            n++;
        end
        check(prev_en, 1'b1, "release follows instruction enable");
        check(core_reset, 1'b0, "core left reset");
        check(core_reset9, 1'b0, "narrow core left reset");
    endtask : wait_release

    task automatic test_done;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    // power-up, clear pin low, then first release and vector wrap
    task automatic t_power_on;
        int n;
        check(core_reset, 1'b1, "held at power-up");
        check(flags, 2'h3, "power-on flags");
        check(pc, 11'h7ff, "vector at power-up");
        rst_n = 1'b1;
        n = 0;
        repeat (3000) begin
            step(1);
            if (core_reset !== 1'b1) n++;
        end
        check(16'(n), 16'h0000, "timer idle while clear low");
        supply_ok = 1'b1;
        pc_req = '{advance: 1'b1, load: 1'b0, addr: 11'h000};
        wait_release(n);
        check(n >= LO && n <= HI, 1'b1, "reset delay length");
        check(pc, 11'h7ff, "vector held in reset");
        check(pc9, 11'h1ff, "narrow vector");
        step(1);
        pc_req = '0;
        check(pc, 11'h000, "vector wraps to zero");
        check(pc9, 11'h000, "narrow vector wraps");
    endtask : t_power_on

    // loads above narrow memory wrap; load wins over advance
    task automatic t_pc_wrap;
        pc_req = '{advance: 1'b1, load: 1'b1, addr: 11'h3ff};
        step(1);
        check(pc, 11'h3ff, "load wins");
        check(pc9, 11'h1ff, "narrow load wraps");
        pc_req = '{advance: 1'b1, load: 1'b0, addr: 11'h000};
        step(1);
        pc_req = '0;
        check(pc, 11'h400, "advance");
        check(pc9, 11'h000, "narrow advance wraps");
    endtask : t_pc_wrap

    // one reset cause, its flags and the full delay after it
    task automatic t_cause(input logic by_watchdog, input logic asleep,
                           input logic [1:0] exp_flags);
        int n;
        sleep = asleep;
        if (by_watchdog) begin
            watchdog = 1'b1;
            step(1);
            watchdog = 1'b0;
        end else begin
            supply_ok = 1'b0;
        end
        n = 0;
        while (core_reset !== 1'b1 && n < 8) begin
            step(1);
            n++;
        end
        check(core_reset, 1'b1, "reset entered");
        sleep = 1'b0;
        supply_ok = 1'b1;
        step(1);
        check(flags, exp_flags, "cause flags");
        check(pc, 11'h7ff, "pc back at vector");
        wait_release(n);
        check(n >= LO && n <= HI, 1'b1, "delay after cause");
    endtask : t_cause

    // watchdog in mid-delay starts the count afresh
    task automatic t_watchdog_restart;
        int n;
        supply_ok = 1'b0;
        step(10);
        supply_ok = 1'b1;
        step(1500);
        watchdog = 1'b1;
        step(1);
        watchdog = 1'b0;
        wait_release(n);
        check(n >= LO, 1'b1, "watchdog restarts delay");
    endtask : t_watchdog_restart

    // second power-up in mid-run restores latch, flags and vector
    task automatic t_repower;
        int n;
        pc_req = '{advance: 1'b1, load: 1'b0, addr: 11'h000};
        step(1);
        pc_req = '0;
        check(pc, 11'h000, "running before second power-up");
        rst_n = 1'b0;
        step(2);
        check(core_reset, 1'b1, "held at second power-up");
        check(flags, 2'h3, "flags at second power-up");
        check(pc, 11'h7ff, "vector at second power-up");
        check(pc9, 11'h1ff, "narrow vector at second power-up");
        rst_n = 1'b1;
        wait_release(n);
        check(n >= LO && n <= HI, 1'b1, "delay after second power-up");
    endtask : t_repower

    initial begin
        step(10);
        t_power_on();
        t_pc_wrap();
        t_cause(1'b1, 1'b0, 2'h1);
        t_cause(1'b0, 1'b0, 2'h1);
        t_cause(1'b0, 1'b1, 2'h2);
        t_cause(1'b1, 1'b1, 2'h0);
        t_cause(1'b0, 1'b0, 2'h0);
        t_watchdog_restart();
        t_repower();
        test_done();
    end

    // cut a hang short
    initial begin
        #(60000 * reset_seq_pkg::CLK_PERIOD_NS);
        fail_count++;
        $display("wrong value at %0t: run did not finish", $time);
        test_done();
    end
endmodule : power_on_reset_timer_tb

`default_nettype wire
